/* File: oag_regs.svh */
// Address constants, window limits and opcode encodings for the operand address generator
`ifndef OAG_REGS_SVH
`define OAG_REGS_SVH

// ********************************
// Address windows
// ********************************
`define OAG_SD_BASE     16'hfe00
`define OAG_SD_LO       16'hfe20
`define OAG_SD_HI       16'hff1f
`define OAG_SD_HIGH_IMM 8'h20
`define OAG_SFR_BASE    16'hff00
`define OAG_SFR_GAP_LO  8'hd0
`define OAG_SFR_GAP_HI  8'hdf
`define OAG_HSRAM_LO    16'hfb00
`define OAG_HSRAM_HI    16'hfeff

// ********************************
// Opcode bytes
// ********************************
`define OAG_OPC_LD_DE   8'h85
`define OAG_OPC_LD_HLB  8'hae
`define OAG_OPC_LD_HLRB 8'hab
`define OAG_OPC_PUSH_DE 8'hb5

`endif

/* File: oag_pkg.sv */
// Types shared by the operand address generator modules
package oag_pkg;

	// ********************************
	// Modes and stack operations
	// ********************************
	typedef enum logic [2:0]
	{
		MD_SHORT  = 3'b000,
		MD_SFR    = 3'b001,
		MD_IND_DE = 3'b010,
		MD_IND_HL = 3'b011,
		MD_BASED  = 3'b100,
		MD_IDX_B  = 3'b101,
		MD_IDX_C  = 3'b110,
		MD_STACK  = 3'b111
	} oag_mode_t;

	typedef enum logic [2:0]
	{
		STK_NONE = 3'b000,
		STK_PUSH = 3'b001,
		STK_POP  = 3'b010,
		STK_CALL = 3'b011,
		STK_RET  = 3'b100,
		STK_INTR = 3'b101
	} oag_stk_t;

	// ********************************
	// Register file view
	// ********************************
	typedef logic [7:0] oag_byte_t;
	typedef oag_byte_t [7:0] oag_bank_t;
	typedef oag_bank_t [3:0] oag_gpr_t;

	typedef struct packed
	{
		logic [15:0] de;
		logic [15:0] hl;
		logic [7:0]  b;
		logic [7:0]  c;
	} oag_pairs_t;

	// ********************************
	// Request and result
	// ********************************
	typedef struct packed
	{
		logic      use_opc;
		logic [7:0] opcode;
		oag_mode_t mode;
		logic [7:0] imm;
		logic      word;
		oag_stk_t  stk;
	} oag_req_t;

	typedef struct packed
	{
		logic [15:0] ea;
		oag_mode_t   mode;
		logic        word;
		logic        align_err;
		logic        range_err;
		logic        opc_err;
	} oag_res_t;

endpackage

/* File: oag_bank_mux.sv */
// Picks the working register pairs of the selected bank
`timescale 1ns/1ps
module oag_bank_mux
(
	// Register file and bank selection
	input  wire oag_pkg::oag_gpr_t   gpr,
	input  wire logic                bank_select_low,
	input  wire logic                bank_select_high,
	// Selected pairs
	output oag_pkg::oag_pairs_t      pairs
);
	import oag_pkg::*;

	oag_bank_t bank;   // Bank chosen by the two select flags

	// Registers sit in order X A C B E D L H inside each bank
	always_comb
	begin
		bank     = gpr[{bank_select_high, bank_select_low}];
		pairs.de = {bank[5], bank[4]};
		pairs.hl = {bank[7], bank[6]};
		pairs.b  = bank[3];
		pairs.c  = bank[2];
	end
endmodule

/* File: oag_opc_dec.sv */
// Recognises the opcode bytes that fix an operand addressing mode
`timescale 1ns/1ps
`include "oag_regs.svh"
module oag_opc_dec
(
	// Opcode in
	input  wire logic [7:0]          opcode,
	// Decoded mode
	output oag_pkg::oag_mode_t       mode,
	output logic                     is_push,
	output logic                     known
);
	import oag_pkg::*;

	// Unknown bytes report a fault rather than guessing a mode
	always_comb
	begin
		mode    = MD_SHORT;
		is_push = 1'b0;
		known   = 1'b1;
		case (opcode)
			`OAG_OPC_LD_DE:   mode = MD_IND_DE;
			`OAG_OPC_LD_HLB:  mode = MD_BASED;
			`OAG_OPC_LD_HLRB: mode = MD_IDX_B;
			`OAG_OPC_PUSH_DE:
			begin
				mode    = MD_STACK;
				is_push = 1'b1;
			end
			default:          known = 1'b0;
		endcase
	end
endmodule

/* File: oag_top.sv */
// Operand effective-address generator for the 8-bit core
`timescale 1ns/1ps
`include "oag_regs.svh"

// Behaviour
// - Short direct: imm below 20H sets bit 8
// - Short direct lands only in FE20H-FF1FH
// - Short direct word accesses use even addresses
// - Special register address is FF00H plus immediate
// - FF00H-FF1FH also reachable by short direct
// - Word special register operand needs even address
// - Indirect uses selected bank's second or base pair
// - Based adds zero-extended offset, carry dropped
// - Indexed adds zero-extended B or C, carry dropped
// - Stack accesses go through stack pointer value
// - Stack operations force stack addressing automatically
// - Stack addresses outside high-speed RAM are flagged, not redirected
// - Opcode 85H loads accumulator via second pair
// - Opcode AEH loads from base plus offset byte
// - Opcode ABH loads from base plus B
// - Opcode B5H pushes second pair on stack
// - FE20H-FEFFH is RAM, FF00H-FF1FH special registers
module oag_top
(
	// Clock and reset
	input  wire logic                CLK_SYS,
	input  wire logic                RESET_N,
	// Request from the sequencer
	input  wire logic                REQ_VALID,
	input  wire oag_pkg::oag_req_t   REQ,
	// Core state
	input  wire oag_pkg::oag_gpr_t   GPR,
	input  wire logic                BANK_SELECT_LOW,
	input  wire logic                BANK_SELECT_HIGH,
	input  wire logic [15:0]         STACK_POINTER,
	// Result to the memory access stage
	output logic                     RES_VALID,
	output oag_pkg::oag_res_t        RES,
	output logic                     RES_RAM
);
	import oag_pkg::*;

	// ************************************************
	// Declarations
	// ************************************************
	oag_pairs_t pairs;        // Pairs of the selected bank
	oag_mode_t  dec_mode;     // Mode fixed by the opcode byte
	logic       dec_push;     // Opcode is a push
	logic       dec_known;    // Opcode is one we handle
	oag_mode_t  mode_c;       // Mode finally used
	oag_stk_t   stk_c;        // Stack operation finally used
	oag_res_t   res_d;        // Next result
	oag_res_t   res_q;        // Registered result
	logic       valid_d;      // Next result strobe
	logic       valid_q;      // Registered result strobe
	logic       ram_d;        // Next RAM-area flag
	logic       ram_q;        // Registered RAM-area flag

	// ************************************************
	// Helpers
	// ************************************************
	oag_bank_mux u_bank
	(
		.gpr              (GPR),
		.bank_select_low  (BANK_SELECT_LOW),
		.bank_select_high (BANK_SELECT_HIGH),
		.pairs            (pairs)
	);

	oag_opc_dec u_dec
	(
		.opcode  (REQ.opcode),
		.mode    (dec_mode),
		.is_push (dec_push),
		.known   (dec_known)
	);

	// ************************************************
	// Mode selection
	// ************************************************
	// A stack operation overrides any requested mode so that calls,
	// returns and interrupt saves never miss the stack
	always_comb
	begin
		mode_c = REQ.mode;
		stk_c  = REQ.stk;
		if (REQ.use_opc && dec_known)
		begin
			mode_c = dec_mode;
			if (dec_push)
				stk_c = STK_PUSH;
		end
		if (stk_c != STK_NONE)
			mode_c = MD_STACK;
	end

	// ************************************************
	// Effective address
	// ************************************************
	// All sums are cut to 16 bits, so carries out of bit 15 vanish
	always_comb
	begin
		res_d           = '0;
		res_d.mode      = mode_c;
		res_d.word      = REQ.word;
		res_d.opc_err   = REQ.use_opc && !dec_known;
		ram_d           = 1'b0;
		valid_d         = REQ_VALID;
		case (mode_c)
			MD_SHORT:
			begin
				// Low immediates fold into the register area
				res_d.ea    = 16'(`OAG_SD_BASE + {8'h00, REQ.imm});
				res_d.ea[8] = (REQ.imm < `OAG_SD_HIGH_IMM);
				ram_d       = !res_d.ea[8];
				if (REQ.word && res_d.ea[0])
				begin
					res_d.align_err = 1'b1;
					res_d.ea[0]     = 1'b0;
				end
			end
			MD_SFR:
			begin
				res_d.ea = 16'(`OAG_SFR_BASE + {8'h00, REQ.imm});
				// The hole between the two register spaces is refused
				if (REQ.imm >= `OAG_SFR_GAP_LO && REQ.imm <= `OAG_SFR_GAP_HI)
					res_d.range_err = 1'b1;
				if (REQ.word && res_d.ea[0])
				begin
					res_d.align_err = 1'b1;
					res_d.ea[0]     = 1'b0;
				end
			end
			MD_IND_DE: res_d.ea = pairs.de;
			MD_IND_HL: res_d.ea = pairs.hl;
			MD_BASED:  res_d.ea = 16'(pairs.hl + {8'h00, REQ.imm});
			MD_IDX_B:  res_d.ea = 16'(pairs.hl + {8'h00, pairs.b});
			MD_IDX_C:  res_d.ea = 16'(pairs.hl + {8'h00, pairs.c});
			default:
			begin
				res_d.ea = STACK_POINTER;
				ram_d    = 1'b1;
				// Outside high-speed RAM the access is flagged, never redirected
				if (STACK_POINTER < `OAG_HSRAM_LO || STACK_POINTER > `OAG_HSRAM_HI)
				begin
					res_d.range_err = 1'b1;
					ram_d           = 1'b0;
				end
			end
		endcase
	end

	// ************************************************
	// Result registers
	// ************************************************
	// One register stage keeps the adder off the memory-stage path
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			res_q   <= '0;
			valid_q <= 1'b0;
			ram_q   <= 1'b0;
		end
		else
		begin
			res_q   <= res_d;
			valid_q <= valid_d;
			ram_q   <= ram_d;
		end
	end

	assign RES       = res_q;
	assign RES_VALID = valid_q;
	assign RES_RAM   = ram_q;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESET_N);

	sequence s_req(oag_mode_t m);
		REQ_VALID && mode_c == m;
	endsequence

	sequence s_done(oag_mode_t m);
		RES_VALID && RES.mode == m;
	endsequence

	a_result_timing: assert property (REQ_VALID |=> RES_VALID ##0 RES.mode == $past(mode_c))
		else $error("result not presented one cycle after request");
	a_short_bit8: assert property (s_req(MD_SHORT) |=> RES.ea[8] == ($past(REQ.imm) < 8'h20))
		else $error("short direct bit 8 wrong");
	a_short_window: assert property (s_done(MD_SHORT) |-> RES.ea >= 16'hfe20 && RES.ea <= 16'hff1f)
		else $error("short direct address outside window");
	a_short_even: assert property (s_done(MD_SHORT) && RES.word |-> !RES.ea[0])
		else $error("short direct word address odd");
	a_sfr_space: assert property (s_req(MD_SFR) |=> RES.ea[15:8] == 8'hff
		&& (RES.range_err == (RES.ea[7:4] == 4'hd)))
		else $error("special register address wrong");
	a_sfr_even: assert property (s_done(MD_SFR) && RES.word |-> !RES.ea[0])
		else $error("special register word address odd");
	a_ind_pair: assert property (s_req(MD_IND_DE) |=> RES.ea == $past(pairs.de))
		else $error("indirect address not the second pair");
	a_based_sum: assert property (s_req(MD_BASED) |=> RES.ea == 16'($past(pairs.hl) + $past(REQ.imm)))
		else $error("based address sum wrong");
	a_index_sum: assert property (s_req(MD_IDX_B) |=> RES.ea == 16'($past(pairs.hl) + $past(pairs.b)))
		else $error("indexed address sum wrong");
	a_stack_sp: assert property (REQ_VALID && REQ.stk != STK_NONE
		|=> RES.mode == MD_STACK && RES.ea == $past(STACK_POINTER))
		else $error("stack operation not through stack pointer");
	a_stack_ram: assert property (s_done(MD_STACK) && !RES.range_err
		|-> RES.ea >= 16'hfb00 && RES.ea <= 16'hfeff && RES_RAM)
		else $error("stack address outside high-speed RAM");
	a_opc_push: assert property (REQ_VALID && REQ.use_opc && REQ.opcode == 8'hb5
		|=> s_done(MD_STACK) ##0 !RES.opc_err)
		else $error("push opcode not decoded");
	a_opc_load: assert property (REQ_VALID && REQ.use_opc && REQ.opcode == 8'h85
		&& REQ.stk == STK_NONE |=> s_done(MD_IND_DE))
		else $error("load opcode not decoded");

	// ************************************************
	// Further checks on addresses, modes, strobes and flags
	// ************************************************
	// An opcode request with no stack operation pending
	sequence s_opc(logic [7:0] o);
		REQ_VALID && REQ.use_opc && REQ.opcode == o && REQ.stk == STK_NONE;
	endsequence

	// A quiet cycle leaves no stale strobe behind
	a_valid_drop: assert property (!REQ_VALID |=> !RES_VALID)
		else $error("result strobe without request");
	// Access width travels with the address
	a_word_kept: assert property (REQ_VALID |=> RES.word == $past(REQ.word))
		else $error("access width not passed on");
	// Base pair of the selected bank used as it stands
	a_ind_hl: assert property (s_req(MD_IND_HL) |=> RES.ea == $past(pairs.hl))
		else $error("indirect address not the base pair");
	// Bank zero read straight from the register file, apart from the mux
	a_ind_bank0: assert property (s_req(MD_IND_DE) && !BANK_SELECT_HIGH && !BANK_SELECT_LOW
		|=> RES.ea == $past({GPR[0][5], GPR[0][4]}))
		else $error("bank zero second pair not used");
	// Index through C wraps like the B form
	a_idx_c: assert property (s_req(MD_IDX_C) |=> RES.ea == 16'($past(pairs.hl) + $past(pairs.c)))
		else $error("indexed address through C wrong");
	// Based sums may wrap but are never refused
	a_based_ok: assert property (s_req(MD_BASED) |=> !RES.range_err && !RES_RAM)
		else $error("based address flagged");
	// Indexed sums may wrap but are never refused
	a_idx_ok: assert property (s_req(MD_IDX_B) |=> !RES.range_err && !RES_RAM)
		else $error("indexed address flagged");
	// RAM flag is the inverse of bit 8 inside the short window
	a_short_ram: assert property (s_done(MD_SHORT) |-> RES_RAM == !RES.ea[8])
		else $error("short direct RAM flag wrong");
	// Low byte of a short address is the immediate itself
	a_short_base: assert property (s_req(MD_SHORT) && !REQ.word
		|=> RES.ea[7:0] == $past(REQ.imm) && RES.ea[15:9] == 7'h7f)
		else $error("short direct base wrong");
	// Low immediates reach the shared special registers
	a_short_sfr: assert property (s_req(MD_SHORT) && REQ.imm < 8'h20
		|=> RES.ea[15:8] == 8'hff && !RES_RAM)
		else $error("short direct low immediate misses registers");
	// Special register low byte is the immediate itself
	a_sfr_base: assert property (s_req(MD_SFR) && !REQ.word |=> RES.ea[7:0] == $past(REQ.imm))
		else $error("special register base wrong");
	// Odd short word requests are flagged
	a_short_odd: assert property (s_req(MD_SHORT) && REQ.word && REQ.imm[0] |=> RES.align_err)
		else $error("odd short word not flagged");
	// Odd special register word requests are flagged
	a_sfr_odd: assert property (s_req(MD_SFR) && REQ.word && REQ.imm[0] |=> RES.align_err)
		else $error("odd special register word not flagged");
	// Byte accesses never raise an alignment fault
	a_byte_align: assert property (REQ_VALID && !REQ.word |=> !RES.align_err)
		else $error("byte access flagged as misaligned");
	// Based load opcode
	a_opc_based: assert property (s_opc(8'hae) |=> s_done(MD_BASED))
		else $error("based load opcode not decoded");
	// Indexed load opcode
	a_opc_index: assert property (s_opc(8'hab) |=> s_done(MD_IDX_B))
		else $error("indexed load opcode not decoded");
	// Unknown opcode bytes are reported
	a_opc_unknown: assert property (REQ_VALID && REQ.use_opc && !dec_known |=> RES.opc_err)
		else $error("unknown opcode not flagged");
	// Plain mode requests never raise an opcode fault
	a_opc_quiet: assert property (REQ_VALID && !REQ.use_opc |=> !RES.opc_err)
		else $error("opcode fault without opcode");
	// Requested mode kept when no stack operation or opcode applies
	a_mode_kept: assert property (REQ_VALID && REQ.stk == STK_NONE && !REQ.use_opc
		|=> RES.mode == $past(REQ.mode))
		else $error("requested mode not kept");
	// A stack pointer above high-speed RAM is flagged
	a_stack_high: assert property (s_req(MD_STACK) && STACK_POINTER > 16'hfeff |=> RES.range_err)
		else $error("stack above RAM not flagged");
	// A flagged stack access is never marked as RAM
	a_stack_flag: assert property (s_done(MD_STACK) && RES.range_err |-> !RES_RAM)
		else $error("flagged stack access marked as RAM");
endmodule

/* File: tb_oag_top.sv */
// Self-checking testbench for the operand address generator
`timescale 1ns/1ps

// Compare one design value with its expectation and count the outcome
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin miscompares++; \
	$display("[ERR] %0t got %h expected %h", $time, (act), (exp)); end end

module tb_oag_top;
	import oag_pkg::*;

	// ********************************
	// Signals and counters
	// ********************************
	logic             clk_sys;       // 250 MHz core clock
	logic             reset_n;       // Asynchronous, active low
	logic             req_valid;     // Request strobe
	oag_req_t         req;           // Request fields
	oag_gpr_t         gpr;           // Register banks
	logic             bank_sel_low;  // Bank select, low bit
	logic             bank_sel_high; // Bank select, high bit
	logic [15:0]      stack_pointer; // Current stack pointer
	logic             res_valid;     // Result strobe
	oag_res_t         res;           // Result fields
	logic             res_ram;       // Result lands in RAM
	int               miscompares;   // Mismatch count
	int               n_compared;    // Comparison count

	oag_top DUT
	(
		.CLK_SYS(clk_sys), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ(req), .GPR(gpr),
		.BANK_SELECT_LOW(bank_sel_low), .BANK_SELECT_HIGH(bank_sel_high),
		.STACK_POINTER(stack_pointer), .RES_VALID(res_valid), .RES(res), .RES_RAM(res_ram)
	);

	// ********************************
	// Shared helpers
	// ********************************
	// Clock: inverted every half period
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	function automatic oag_req_t rq(logic u, logic [7:0] o, oag_mode_t m, logic [7:0] i, logic w, oag_stk_t s);
		rq = '{u, o, m, i, w, s};
	endfunction

	// One request, judged one edge later; strobe stays up so calls run back to back
	// Flags f are align, range, opcode and RAM in that order
	task automatic issue(oag_req_t r, logic [15:0] ea, oag_mode_t m, logic [3:0] f);
		req_valid = 1'b1;
		req = r;
		@(posedge clk_sys);
		#1;
		`CHK(res_valid, 1'b1)
		`CHK(res.ea, ea)
		`CHK(res.mode, m)
		`CHK(res.word, r.word)
		`CHK({res.align_err, res.range_err, res.opc_err, res_ram}, f)
	endtask

	// Drop the strobe and see the result strobe fall after one edge
	task automatic idle();
		req_valid = 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK(res_valid, 1'b0)
	endtask

	// ********************************
	// Scenarios
	// ********************************
	// Window edges of short direct, back to back, with word alignment
	task automatic t_short();
		issue(rq(0, 8'h00, MD_SHORT, 8'h00, 0, STK_NONE), 16'hff00, MD_SHORT, 4'h0);
		issue(rq(0, 8'h00, MD_SHORT, 8'h1f, 0, STK_NONE), 16'hff1f, MD_SHORT, 4'h0);
		issue(rq(0, 8'h00, MD_SHORT, 8'h20, 0, STK_NONE), 16'hfe20, MD_SHORT, 4'h1);
		issue(rq(0, 8'h00, MD_SHORT, 8'hff, 0, STK_NONE), 16'hfeff, MD_SHORT, 4'h1);
		issue(rq(0, 8'h00, MD_SHORT, 8'h1e, 1, STK_NONE), 16'hff1e, MD_SHORT, 4'h0);
		issue(rq(0, 8'h00, MD_SHORT, 8'h31, 1, STK_NONE), 16'hfe30, MD_SHORT, 4'h9);
		idle();
	endtask

	// Special register space, gap flagged, odd word flagged
	task automatic t_sfr();
		issue(rq(0, 8'h00, MD_SFR, 8'h20, 0, STK_NONE), 16'hff20, MD_SFR, 4'h0);
		issue(rq(0, 8'h00, MD_SFR, 8'hd0, 0, STK_NONE), 16'hffd0, MD_SFR, 4'h4);
		issue(rq(0, 8'h00, MD_SFR, 8'he1, 1, STK_NONE), 16'hffe0, MD_SFR, 4'h8);
		idle();
	endtask

	// Pair modes in every bank; sums wrap and offsets above 7FH stay positive
	task automatic t_pairs();
		for (int k = 0; k < 4; k++)
		begin
			{bank_sel_high, bank_sel_low} = k[1:0];
			issue(rq(0, 8'h00, MD_IND_DE, 8'h00, 0, STK_NONE), {8'h10 + k[7:0], 8'h34}, MD_IND_DE, 4'h0);
			issue(rq(0, 8'h00, MD_IND_HL, 8'h00, 0, STK_NONE), 16'hfff0 + k[15:0], MD_IND_HL, 4'h0);
			issue(rq(0, 8'h00, MD_BASED, 8'h80, 0, STK_NONE), 16'h0070 + k[15:0], MD_BASED, 4'h0);
			issue(rq(0, 8'h00, MD_IDX_B, 8'h00, 0, STK_NONE), 16'h00b0 + 2 * k[15:0], MD_IDX_B, 4'h0);
			issue(rq(0, 8'h00, MD_IDX_C, 8'h00, 0, STK_NONE), 16'h0010 + 2 * k[15:0], MD_IDX_C, 4'h0);
		end
		idle();
	endtask

	// Opcode bytes override the mode field; an unknown byte is flagged
	task automatic t_opcodes();
		{bank_sel_high, bank_sel_low} = 2'b00;
		stack_pointer = 16'hfe80;
		issue(rq(1, 8'h85, MD_SHORT, 8'h00, 0, STK_NONE), 16'h1034, MD_IND_DE, 4'h0);
		issue(rq(1, 8'hae, MD_SHORT, 8'h10, 0, STK_NONE), 16'h0000, MD_BASED, 4'h0);
		issue(rq(1, 8'hab, MD_SHORT, 8'h00, 0, STK_NONE), 16'h00b0, MD_IDX_B, 4'h0);
		issue(rq(1, 8'hb5, MD_SHORT, 8'h00, 0, STK_NONE), 16'hfe80, MD_STACK, 4'h1);
		issue(rq(1, 8'h00, MD_SFR, 8'h20, 0, STK_NONE), 16'hff20, MD_SFR, 4'h2);
		idle();
	endtask

	// Every stack operation forces the stack pointer; outside RAM is flagged
	task automatic t_stack();
		oag_stk_t ops[5];
		ops = '{STK_PUSH, STK_POP, STK_CALL, STK_RET, STK_INTR};
		for (int i = 0; i < 5; i++)
		begin
			stack_pointer = 16'hfb00 + 16'(4 * i);
			issue(rq(0, 8'h00, MD_SFR, 8'h20, 0, ops[i]), 16'hfb00 + 16'(4 * i), MD_STACK, 4'h1);
		end
		stack_pointer = 16'hfeff;
		issue(rq(0, 8'h00, MD_SHORT, 8'h00, 0, STK_POP), 16'hfeff, MD_STACK, 4'h1);
		stack_pointer = 16'hff10;
		issue(rq(0, 8'h00, MD_SHORT, 8'h00, 0, STK_PUSH), 16'hff10, MD_STACK, 4'h4);
		stack_pointer = 16'hfaff;
		issue(rq(0, 8'h00, MD_SHORT, 8'h00, 0, STK_CALL), 16'hfaff, MD_STACK, 4'h4);
		idle();
	endtask

	// Reset in mid-run clears the result at once, and nothing follows release
	task automatic t_reset();
		issue(rq(0, 8'h00, MD_SHORT, 8'h40, 0, STK_NONE), 16'hfe40, MD_SHORT, 4'h1);
		reset_n = 1'b0;
		#1;
		`CHK({res_valid, res, res_ram}, '0)
		req_valid = 1'b0;
		@(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		idle();
	endtask

	// ********************************
	// Run control
	// ********************************
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog: the run needs well under a hundred cycles
	initial
	begin
		#4000;
		miscompares++;
		conclude();
	end

	// Main sequence: reset for two cycles, then each scenario
	initial
	begin
		miscompares = 0;
		n_compared = 0;
		reset_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		gpr = '0;
		bank_sel_low = 1'b0;
		bank_sel_high = 1'b0;
		stack_pointer = 16'h0000;
		for (int k = 0; k < 4; k++)
		begin
			gpr[k][5] = 8'h10 + k[7:0];
			gpr[k][4] = 8'h34;
			gpr[k][7] = 8'hff;
			gpr[k][6] = 8'hf0 + k[7:0];
			gpr[k][3] = 8'hc0 + k[7:0];
			gpr[k][2] = 8'h20 + k[7:0];
		end
		repeat (2) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		t_short();
		t_sfr();
		t_pairs();
		t_opcodes();
		t_stack();
		t_reset();
		conclude();
	end
endmodule
